//--- verilog/apmcr_regs.sv
// apmcr_regs: power management control registers with AHB-Lite access
//
// How it works
// R1: power_control is 8 bits, resets to 18h
// R2: claim enabled: port cycles serviced, reads not forwarded
// R3: claim disabled: port cycles forwarded to PCI
// R4: port decoded at programmable address, default 0022h
// R5: bit 4 read-only, always reads one
// R6: bit 3 read-only, always reads one
// R7: options register 8 bits, resets to 00h
// R8: forward bit set: port writes go to PCI
// R9: forward bit clear: claimed port writes kept internal
// R10: power saving gates memory cke to activity
// R11: power saving adds one clock latency
// R12: power saving independent of processor clock states
// R13: clock mode status reports off, normal, saving
// R14: port address 16-bit read/write, resets 22h
// R15: reserved bits read zero, ignore writes
`timescale 1ns/1ps
`default_nettype none
module apmcr_regs (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// processor i/o cycles
	input wire logic io_valid,
	input wire logic [15:0] io_addr,
	input wire logic io_write,
	output logic io_claimed,
	output logic io_forwarded,
	// memory controller
	input wire logic mem_clock_off,
	input wire logic [apmcr_pkg::NUM_SLOTS-1:0] mem_req,
	input wire logic [apmcr_pkg::NUM_SLOTS-1:0] mem_refresh,
	output logic [apmcr_pkg::NUM_SLOTS-1:0] mem_cke,
	output logic [apmcr_pkg::NUM_SLOTS-1:0] mem_go,
	output logic [1:0] clock_mode_status
);
	import apmcr_pkg::*;

	// ==========================================
	// state
	apmcr_regs_s st_reg; // all registered state
	apmcr_regs_s st_next; // its next value
	logic addr_phase; // valid address phase this cycle
	logic [31:0] rd_val; // read data of the pending read
	logic port_hit; // i/o cycle to the acpi control port
	logic claim_en; // acpi_port_claim_enable
	logic arb_fwd; // arbiter_port_forward
	logic psm; // memory_power_saving

	assign claim_en = st_reg.pwr_ctl[PC_CLAIM_BIT];
	assign arb_fwd = st_reg.pwr_opt[OPT_FWD_BIT];
	// only the options bit drives saving; no processor clock state feeds it
	assign psm = st_reg.pwr_opt[OPT_PSM_BIT]; // R12

	assign addr_phase = hsel & htrans[1] & hready;
	assign port_hit = io_valid & (io_addr == st_reg.port_addr); // R4

	// ==========================================
	// read data mux
	always_comb begin
		rd_val = 32'h00000000;
		if (st_reg.dp_map) begin
			unique case (st_reg.dp_idx)
				IDX_PORT_ADDR: rd_val = {16'h0000, st_reg.port_addr}; // R14
				// indicators forced on, reserved bits zero
				IDX_PWR_CTL: rd_val = {24'h000000, st_reg.pwr_ctl | PWR_CTL_RO_MASK}; // R5 R6
				IDX_PWR_OPT: rd_val = {24'h000000, st_reg.pwr_opt & PWR_OPT_RW_MASK}; // R15
				IDX_CLK_STAT: rd_val = {30'h0, st_reg.clk_stat};
				default: rd_val = 32'h00000000; // unmapped reads zero
			endcase
		end
	end

	// ==========================================
	// next state
	always_comb begin
		st_next = st_reg;
		// ---- write data phase: hwdata stands now
		if (st_reg.dp_wr && st_reg.dp_map) begin
			unique case (st_reg.dp_idx)
				IDX_PORT_ADDR: begin
					st_next.port_addr[7:0] = hwdata[7:0]; // R14
					if (!st_reg.dp_byte) begin
						st_next.port_addr[15:8] = hwdata[15:8];
					end
				end
				IDX_PWR_CTL: begin
					// read-only and reserved bits ignore writes
					st_next.pwr_ctl = (hwdata[7:0] & PWR_CTL_RW_MASK) | PWR_CTL_RO_MASK; // R1 R15
				end
				IDX_PWR_OPT: begin
					st_next.pwr_opt = hwdata[7:0] & PWR_OPT_RW_MASK; // R7 R15
				end
				default: begin
					st_next.pwr_opt = st_reg.pwr_opt; // unmapped or read-only: ignored
				end
			endcase
		end
		if (st_reg.dp_wr) begin
			st_next.dp_wr = 1'b0;
		end
		// ---- read data phase: one wait state, data from a register
		if (st_reg.dp_rd) begin
			st_next.hrdata = rd_val;
			st_next.hready = 1'b1;
			st_next.dp_rd = 1'b0;
		end
		// ---- address phase
		if (addr_phase) begin
			st_next.dp_idx = haddr[9:2];
			st_next.dp_map = (haddr[31:10] == MAP_UPPER);
			st_next.dp_byte = (hsize == HSIZE_BYTE);
			st_next.dp_wr = hwrite;
			st_next.dp_rd = !hwrite;
			st_next.hready = hwrite; // reads stall one cycle
		end
		// ---- acpi control port i/o cycles
		st_next.io_claim = 1'b0;
		st_next.io_fwd = 1'b0;
		if (port_hit) begin
			if (!claim_en) begin
				st_next.io_fwd = 1'b1; // R3
			end else if (io_write) begin
				st_next.io_claim = 1'b1; // R2
				st_next.io_fwd = arb_fwd; // R8 R9
			end else begin
				st_next.io_claim = 1'b1; // R2
			end
		end
		// ---- clock mode status
		st_next.clk_stat[STAT_OFF_BIT] = mem_clock_off; // R13
		st_next.clk_stat[STAT_PSM_BIT] = psm & !mem_clock_off; // R13
	end

	// ==========================================
	// state register
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			st_reg.pwr_ctl <= PWR_CTL_RST; // R1
			st_reg.pwr_opt <= PWR_OPT_RST; // R7
			st_reg.port_addr <= PORT_ADDR_RST; // R4 R14
			st_reg.dp_wr <= 1'b0;
			st_reg.dp_rd <= 1'b0;
			st_reg.dp_idx <= 8'h00;
			st_reg.dp_map <= 1'b0;
			st_reg.dp_byte <= 1'b0;
			st_reg.hready <= 1'b1;
			st_reg.hrdata <= 32'h00000000;
			st_reg.io_claim <= 1'b0;
			st_reg.io_fwd <= 1'b0;
			st_reg.clk_stat <= CLK_STAT_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	// ==========================================
	// memory slot clock-enable gates
	genvar gi;
	generate
		for (gi = 0; gi < NUM_SLOTS; gi++) begin : g_slot
			apmcr_slot_cke u_slot (
				.core_clk(core_clk),
				.rst_b(rst_b),
				.psm(psm),
				.clock_off(mem_clock_off),
				.req(mem_req[gi]),
				.refresh(mem_refresh[gi]),
				.cke(mem_cke[gi]),
				.go(mem_go[gi])
			);
		end
	endgenerate

	// ==========================================
	// outputs
	assign hreadyout = st_reg.hready;
	assign hresp = HRESP_OKAY; // always okay
	assign hrdata = st_reg.hrdata;
	assign io_claimed = st_reg.io_claim;
	assign io_forwarded = st_reg.io_fwd;
	assign clock_mode_status = st_reg.clk_stat;

	// ==========================================
	// assertions
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	// helper: a power_control read finishing next edge
	logic rd_pc_done;
	assign rd_pc_done = st_reg.dp_rd && st_reg.dp_map && (st_reg.dp_idx == IDX_PWR_CTL);

	a_reset_values: assert property ( // R1
		$rose(rst_b) |-> st_reg.pwr_ctl == 8'h18 && st_reg.pwr_opt == 8'h00)
		else $error("registers not at reset values");
	a_port_default: assert property ( // R14
		$rose(rst_b) |-> st_reg.port_addr == 16'h0022)
		else $error("port address not 0022h after reset");
	a_claim_read: assert property ( // R2
		port_hit && claim_en && !io_write |=> io_claimed && !io_forwarded)
		else $error("claimed port read was not serviced internally");
	a_forward_all: assert property ( // R3
		port_hit && !claim_en |=> io_forwarded && !io_claimed)
		else $error("port cycle not forwarded while claim disabled");
	a_miss_quiet: assert property ( // R4
		io_valid && io_addr != st_reg.port_addr |=> !io_claimed && !io_forwarded)
		else $error("cycle outside the port address was acted on");
	a_nref_one: assert property ( // R5
		rd_pc_done |=> hreadyout && hrdata[4])
		else $error("normal refresh indicator read as zero");
	a_qs_one: assert property ( // R6
		rd_pc_done |=> hrdata[3] && hrdata[2:0] == 3'h0)
		else $error("quick start indicator or low bits wrong");
	a_reserved_zero: assert property ( // R15
		rd_pc_done |=> hrdata[7] == 1'b0 && hrdata[5] == 1'b0 && hrdata[31:8] == 24'h000000)
		else $error("reserved power_control bits read nonzero");
	a_opt_write: assert property ( // R7
		st_reg.dp_wr && st_reg.dp_map && st_reg.dp_idx == IDX_PWR_OPT
		|=> st_reg.pwr_opt == ($past(hwdata[7:0]) & 8'h41))
		else $error("options write stored wrong value");
	a_arb_forward: assert property ( // R8
		port_hit && claim_en && io_write && arb_fwd |=> io_forwarded && io_claimed)
		else $error("arbiter port write not forwarded");
	a_arb_internal: assert property ( // R9
		port_hit && claim_en && io_write && !arb_fwd |=> !io_forwarded && io_claimed)
		else $error("arbiter port write leaked to pci");
	a_cke_gated: assert property ( // R10
		psm && !mem_clock_off && !mem_req[0] && !mem_refresh[0] |=> !mem_cke[0])
		else $error("cke high while idle in saving mode");
	a_extra_clock: assert property ( // R11
		psm && !mem_cke[0] && mem_req[0] && !mem_clock_off
		##1 psm && mem_req[0] && !mem_clock_off |=> mem_go[0] && !$past(mem_go[0]))
		else $error("saving mode latency not exactly one extra clock");
	a_mode_status: assert property ( // R13
		!mem_clock_off ##1 !mem_clock_off
		|-> clock_mode_status == {$past(psm), 1'b0})
		else $error("clock mode status disagrees with saving bit");
	a_psm_steady: assert property ( // R12
		!st_reg.dp_wr |=> $stable(psm))
		else $error("saving bit changed without a register write");

	c_read_ctl: cover property (rd_pc_done ##1 hreadyout);
	c_claim: cover property (port_hit && claim_en ##1 io_claimed);
	c_fwd_write: cover property (port_hit && io_write && claim_en && arb_fwd ##1 io_forwarded);
	c_psm_gate: cover property (psm && !mem_cke[0] ##1 mem_cke[0] ##1 mem_go[0]);
endmodule
`default_nettype wire

//--- verilog/apmcr_pkg.sv
// apmcr_pkg: constants and state types for the power management control registers
`default_nettype none
package apmcr_pkg;
	// ==========================================
	// register indices (byte address = 4 * index)
	localparam logic [7:0] IDX_PORT_ADDR = 8'h78; // acpi_port_address, 16 bits
	localparam logic [7:0] IDX_PWR_CTL = 8'h7A; // power_control
	localparam logic [7:0] IDX_PWR_OPT = 8'h7B; // power_control_options
	localparam logic [7:0] IDX_CLK_STAT = 8'h7C; // sdram_clock_mode_status
	// ==========================================
	// field positions
	localparam int PC_CLAIM_BIT = 6; // acpi_port_claim_enable
	localparam int PC_NREF_BIT = 4; // normal_refresh_indicator
	localparam int PC_QS_BIT = 3; // quick_start_indicator
	localparam int OPT_FWD_BIT = 6; // arbiter_port_forward
	localparam int OPT_PSM_BIT = 0; // memory_power_saving
	localparam int STAT_OFF_BIT = 0; // controller in clock-off mode
	localparam int STAT_PSM_BIT = 1; // controller in power-saving mode
	// ==========================================
	// reset values and masks
	localparam logic [7:0] PWR_CTL_RST = 8'h18;
	localparam logic [7:0] PWR_CTL_RO_MASK = 8'h18; // indicators forced to one
	localparam logic [7:0] PWR_CTL_RW_MASK = 8'h40; // claim enable only
	localparam logic [7:0] PWR_OPT_RST = 8'h00;
	localparam logic [7:0] PWR_OPT_RW_MASK = 8'h41; // forward and power saving
	localparam logic [15:0] PORT_ADDR_RST = 16'h0022;
	localparam logic [1:0] CLK_STAT_RST = 2'h0;
	// ==========================================
	// bus and sizing
	localparam int NUM_SLOTS = 2; // attached memory slots
	localparam logic HRESP_OKAY = 1'h0;
	localparam logic [2:0] HSIZE_BYTE = 3'h0;
	localparam logic [21:0] MAP_UPPER = 22'h0; // haddr[31:10] of mapped space
	// ==========================================
	// state of one memory slot clock-enable gate
	typedef struct packed {
		logic cke; // clock enable to the memory
		logic go; // access may proceed this cycle
	} apmcr_slot_s;
	// state of the register block
	typedef struct packed {
		logic [7:0] pwr_ctl;
		logic [7:0] pwr_opt;
		logic [15:0] port_addr;
		logic dp_wr; // write data phase pending
		logic dp_rd; // read data phase pending
		logic [7:0] dp_idx; // register index of the data phase
		logic dp_map; // address lies in mapped space
		logic dp_byte; // byte sized transfer
		logic hready;
		logic [31:0] hrdata;
		logic io_claim;
		logic io_fwd;
		logic [1:0] clk_stat;
	} apmcr_regs_s;
endpackage
`default_nettype wire

//--- verilog/apmcr_slot_cke.sv
// apmcr_slot_cke: clock-enable gate and access latency for one memory slot
`timescale 1ns/1ps
`default_nettype none
module apmcr_slot_cke (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// mode
	input wire logic psm, // memory power saving on
	input wire logic clock_off, // controller in clock-off mode
	// slot activity
	input wire logic req, // access wanted, held until go
	input wire logic refresh, // refresh in progress
	// to memory and controller
	output logic cke,
	output logic go
);
	import apmcr_pkg::*;
	apmcr_slot_s st_reg;
	apmcr_slot_s st_next;

	// ==========================================
	// next state
	always_comb begin
		st_next = st_reg;
		// clock-off drops cke; normal keeps it high; saving raises it on demand
		if (clock_off) begin
			st_next.cke = 1'b0;
		end else if (!psm) begin
			st_next.cke = 1'b1;
		end else begin
			st_next.cke = req | refresh; // R10
		end
		// saving mode waits for cke to be up first: one extra clock
		st_next.go = req & !clock_off & (!psm | st_reg.cke); // R11
	end

	// ==========================================
	// state register
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			st_reg <= '{cke: 1'b1, go: 1'b0};
		end else begin
			st_reg <= st_next;
		end
	end

	assign cke = st_reg.cke;
	assign go = st_reg.go;
endmodule
`default_nettype wire

//--- dv/apmcr_host.sv
// apmcr_host: processor i/o cycle source that also sees the forward answer
`timescale 1ns/1ps
`default_nettype none
module apmcr_host (
	// clock
	input wire logic core_clk,
	// i/o cycle to the bridge
	output logic io_valid,
	output logic [15:0] io_addr,
	output logic io_write,
	// bridge answer
	input wire logic io_claimed,
	input wire logic io_forwarded
);
	// idle bus carries no stale address
	initial begin
		io_valid = 1'h0;
		io_addr = 16'hFFFF;
		io_write = 1'h0;
	end
	// one cycle; answer pulse sampled one edge after the taking edge
	task automatic cycle(input logic [15:0] a, input logic w, output logic [1:0] ans);
		io_valid <= 1'h1;
		io_addr <= a;
		io_write <= w;
		@(posedge core_clk);
		io_valid <= 1'h0;
		io_addr <= ~a;
		io_write <= ~w;
		@(posedge core_clk);
		ans = {io_claimed, io_forwarded};
	endtask
endmodule
`default_nettype wire

//--- dv/apmcr_regs_tb.sv
// apmcr_regs_tb: self-checking bench for the power management registers
`timescale 1ns/1ps
`default_nettype none
module apmcr_regs_tb;
	import apmcr_pkg::*;
	// ==========================================
	// signals
	typedef struct packed {
		logic w;
		logic [7:0] i;
		logic [31:0] d;
		logic [31:0] e;
	} apmcr_row_s;
	logic core_clk = 1'h0, rst_b = 1'h0, hsel = 1'h0, hwrite = 1'h0, hreadyout, hresp;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
	logic [1:0] htrans = 2'h0, ans, mem_cke, mem_go, clock_mode_status;
	logic [2:0] hsize = 3'h2;
	logic io_valid, io_write, io_claimed, io_forwarded, mem_clock_off = 1'h0;
	logic [15:0] io_addr;
	logic [1:0] mem_req = 2'h0, mem_refresh = 2'h0;
	int n_fail = 0, checked = 0;
	// register cases: write flag, index, data, expected read
	localparam apmcr_row_s ROWS[10] = '{
		'{1'h0, IDX_PWR_CTL, 32'h0, 32'h18},
		'{1'h0, IDX_PWR_OPT, 32'h0, 32'h0},
		'{1'h0, IDX_PORT_ADDR, 32'h0, 32'h22},
		'{1'h0, IDX_CLK_STAT, 32'h0, 32'h0},
		'{1'h1, IDX_PWR_CTL, 32'hFFFFFFFF, 32'h58},
		'{1'h1, IDX_PWR_CTL, 32'h0, 32'h18},
		'{1'h1, IDX_PWR_OPT, 32'hFFFFFFFF, 32'h41},
		'{1'h1, IDX_PWR_OPT, 32'h0, 32'h0},
		'{1'h1, IDX_PORT_ADDR, 32'h5A5A0030, 32'h30},
		'{1'h1, 8'h70, 32'hFFFFFFFF, 32'h0}};
	// ==========================================
	// clock, design and host
	always #12.5 core_clk = ~core_clk;
	apmcr_regs u_apmcr_regs (.core_clk(core_clk), .rst_b(rst_b), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.io_valid(io_valid), .io_addr(io_addr), .io_write(io_write),
		.io_claimed(io_claimed), .io_forwarded(io_forwarded),
		.mem_clock_off(mem_clock_off), .mem_req(mem_req), .mem_refresh(mem_refresh),
		.mem_cke(mem_cke), .mem_go(mem_go), .clock_mode_status(clock_mode_status));
	apmcr_host u_apmcr_host (.core_clk(core_clk), .io_valid(io_valid), .io_addr(io_addr),
		.io_write(io_write), .io_claimed(io_claimed), .io_forwarded(io_forwarded));
	// ==========================================
	// helpers
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// one single ahb-lite transfer, entered just after a rising edge
	task automatic ahb(input logic w, input logic [7:0] i, input logic [31:0] d,
		output logic [31:0] q);
		hsel <= 1'h1;
		htrans <= 2'h2;
		haddr <= {22'h0, i, 2'h0};
		hwrite <= w;
		@(posedge core_clk);
		while (hreadyout !== 1'h1) @(posedge core_clk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge core_clk);
		while (hreadyout !== 1'h1) @(posedge core_clk);
		q = hrdata;
		chk(hresp, HRESP_OKAY);
	endtask
	task automatic final_report();
		$display("checks %0d, mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// ==========================================
	// watchdog against a hang
	initial begin
		repeat (5000) @(posedge core_clk);
		n_fail++;
		final_report();
	end
	// ==========================================
	// main sequence
	initial begin
		repeat (2) @(posedge core_clk);
		rst_b <= 1'h1;
		// ordinary register cases
		foreach (ROWS[k]) begin
			if (ROWS[k].w) ahb(1'h1, ROWS[k].i, ROWS[k].d, r);
			ahb(1'h0, ROWS[k].i, 32'h0, r);
			chk(r, ROWS[k].e);
		end
		// every claim, forward and direction pairing at the moved port
		for (int k = 0; k < 8; k++) begin
			ahb(1'h1, IDX_PWR_CTL, {25'h0, k[2], 6'h0}, r);
			ahb(1'h1, IDX_PWR_OPT, {25'h0, k[1], 6'h0}, r);
			u_apmcr_host.cycle(16'h0030, k[0], ans);
			chk(ans, {k[2], !k[2] | (k[0] & k[1])});
		end
		// old default port no longer decoded
		u_apmcr_host.cycle(16'h0022, 1'h1, ans);
		chk(ans, 2'h0);
		// normal mode: go one cycle after request
		mem_req <= 2'h1;
		repeat (2) @(posedge core_clk);
		chk(mem_go, 2'h1);
		mem_req <= 2'h0;
		ahb(1'h1, IDX_PWR_OPT, 32'h1, r);
		repeat (2) @(posedge core_clk);
		chk(mem_cke, 2'h0);
		chk(clock_mode_status, 2'h2);
		ahb(1'h0, IDX_PWR_CTL, 32'h0, r);
		chk(r, 32'h58);
		// saving mode: cke then go, one extra cycle
		mem_req <= 2'h3;
		@(posedge core_clk);
		@(posedge core_clk);
		chk({mem_cke, mem_go}, 4'hC);
		@(posedge core_clk);
		chk(mem_go, 2'h3);
		mem_req <= 2'h0;
		mem_refresh <= 2'h1;
		repeat (2) @(posedge core_clk);
		chk(mem_cke, 2'h1);
		mem_refresh <= 2'h0;
		mem_clock_off <= 1'h1;
		repeat (2) @(posedge core_clk);
		chk({mem_cke, clock_mode_status}, 4'h1);
		mem_clock_off <= 1'h0;
		// reset in mid-run restores defaults
		rst_b <= 1'h0;
		repeat (2) @(posedge core_clk);
		rst_b <= 1'h1;
		ahb(1'h0, IDX_PWR_OPT, 32'h0, r);
		chk(r, 32'h0);
		ahb(1'h0, IDX_PORT_ADDR, 32'h0, r);
		chk(r, 32'h22);
		ahb(1'h0, IDX_PWR_CTL, 32'h0, r);
		chk(r, 32'h18);
		final_report();
	end
endmodule
`default_nettype wire
